// ---- rtl/urb_map.vh ----
`ifndef URB_MAP_VH
`define URB_MAP_VH

// register byte offsets
`define URB_OFS_STATUS 12'h000
`define URB_OFS_CTRL_B 12'h004
`define URB_OFS_CTRL_C 12'h008
`define URB_OFS_DATA 12'h00c

// status register fields
`define URB_ST_RXC 7
`define URB_ST_FE 4
`define URB_ST_DOR 3
`define URB_ST_PE 2

// control b fields
`define URB_CB_RX_COMPLETE_IRQ_ENABLE 7
`define URB_CB_RECEIVER_ENABLE_BIT 4
`define URB_CB_SZ2 2
`define URB_CB_RX9 1

// control c fields
`define URB_CC_PEN 5
`define URB_CC_PODD 4
`define URB_CC_SBS 3
`define URB_CC_SZ_HI 2
`define URB_CC_SZ_LO 1

// reset values
`define URB_RST_CTRL_B 8'h00
`define URB_RST_CTRL_C 8'h06

// char size code for nine data bits
`define URB_SZ_NINE 3'h7

// serial bit time in pclk cycles
`define URB_BIT_CYCLES 12'd1736
`define URB_HALF_CYCLES 12'd868

// buffer depth in frames
`define URB_BUF_DEPTH 2'd2

`endif

// ---- rtl/urb_rx.v ----
`include "urb_map.vh"
`default_nettype none

module urb_rx (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // serial pin
  input wire rx_pin,
  output wire rx_pin_override,
  // interrupt
  input wire global_irq_enable,
  output wire rx_irq
);

  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_PAR = 3'd3;
  localparam ST_STOP = 3'd4;

  reg [7:0] ctrl_b_r;
  reg [7:0] ctrl_c_r;
  reg rx_s1_r;
  reg rx_s2_r;
  reg rx_s3_r;
  reg [2:0] state_r;
  reg [11:0] cnt_r;
  reg [3:0] bitn_r;
  reg [3:0] nbits_r;
  reg par_en_r;
  reg par_odd_r;
  reg par_bit_r;
  reg [8:0] sh_data_r;
  reg sh_fe_r;
  reg sh_full_r;
  reg dor_pend_r;
  reg [11:0] mem_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] count_r;
  reg rd_valid_r;

  wire receiver_enable_bit = ctrl_b_r[`URB_CB_RECEIVER_ENABLE_BIT];
  wire rx_complete_irq_enable = ctrl_b_r[`URB_CB_RX_COMPLETE_IRQ_ENABLE];
  wire parity_enable_bit = ctrl_c_r[`URB_CC_PEN];
  wire parity_odd_select = ctrl_c_r[`URB_CC_PODD];
  wire stop_bit_count_select = ctrl_c_r[`URB_CC_SBS];
  wire [2:0] char_size_field = {ctrl_b_r[`URB_CB_SZ2], ctrl_c_r[`URB_CC_SZ_HI:`URB_CC_SZ_LO]};

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire rd_data = access & ~pwrite & (paddr == `URB_OFS_DATA);
  wire mapped = (paddr == `URB_OFS_STATUS) | (paddr == `URB_OFS_CTRL_B) |
                (paddr == `URB_OFS_CTRL_C) | (paddr == `URB_OFS_DATA);

  wire rx_complete_flag = receiver_enable_bit & (count_r != 2'd0);
  wire buf_full = (count_r == `URB_BUF_DEPTH);
  wire [11:0] head = mem_r[rd_ptr_r];
  // entry layout: {dor, pe, fe, data[8:0]}
  wire overrun_flag = rx_complete_flag & head[11];
  wire parity_error_flag = rx_complete_flag & head[10];
  wire frame_error_flag = rx_complete_flag & head[9];
  wire rx_ninth_bit = rx_complete_flag & head[8];
  wire pop = rd_data & rd_valid_r;
  wire push = sh_full_r & ~buf_full & receiver_enable_bit;
  wire fall = receiver_enable_bit & rx_s3_r & ~rx_s2_r;

  assign pready = 1'b1;
  assign rx_pin_override = receiver_enable_bit;
  // only completion is gated out; error flags never reach here
  assign rx_irq = rx_complete_irq_enable & rx_complete_flag & global_irq_enable;

  function [3:0] size_bits;
    input [2:0] sz;
    begin
      case (sz)
        3'h0: size_bits = 4'd5;
        3'h1: size_bits = 4'd6;
        3'h2: size_bits = 4'd7;
        `URB_SZ_NINE: size_bits = 4'd9;
        default: size_bits = 4'd8;
      endcase
    end
  endfunction

  // pin synchroniser; rx_s1_r feeds only rx_s2_r
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  // control registers; status has no writable bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_b_r <= `URB_RST_CTRL_B;
      ctrl_c_r <= `URB_RST_CTRL_C;
    end
    else if (wr_en)
    begin
      if (paddr == `URB_OFS_CTRL_B)
        ctrl_b_r <= {pwdata[7:2], 2'b00};
      if (paddr == `URB_OFS_CTRL_C)
        ctrl_c_r <= pwdata[7:0];
    end
  end

  // read data captured in setup so the head cannot shift under the master
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      rd_valid_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= ~mapped;
      rd_valid_r <= rx_complete_flag;
      case (paddr)
        `URB_OFS_STATUS:
          prdata <= {24'h00_0000, rx_complete_flag, 2'b00, frame_error_flag,
                     overrun_flag, parity_error_flag, 2'b00};
        `URB_OFS_CTRL_B:
          prdata <= {24'h00_0000, ctrl_b_r[7:2], rx_ninth_bit, 1'b0};
        `URB_OFS_CTRL_C:
          prdata <= {24'h00_0000, ctrl_c_r};
        `URB_OFS_DATA:
          prdata <= {24'h00_0000, rx_complete_flag ? head[7:0] : 8'h00};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // receive sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
      bitn_r <= 4'h0;
      nbits_r <= 4'h8;
      par_en_r <= 1'b0;
      par_odd_r <= 1'b0;
      par_bit_r <= 1'b0;
      sh_data_r <= 9'h000;
      sh_fe_r <= 1'b0;
      sh_full_r <= 1'b0;
      dor_pend_r <= 1'b0;
    end
    else if (!receiver_enable_bit)
    begin
      // immediate stop, partial frame dropped
      state_r <= ST_IDLE;
      sh_full_r <= 1'b0;
      dor_pend_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        sh_full_r <= 1'b0;
        dor_pend_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE:
        begin
          if (fall)
          begin
            // frame waits in shifter and buffer full: new one is lost
            if (sh_full_r & buf_full)
              dor_pend_r <= 1'b1;
            else
            begin
              state_r <= ST_START;
              cnt_r <= `URB_HALF_CYCLES;
            end
          end
        end
        ST_START:
        begin
          if (cnt_r == 12'h000)
          begin
            if (!rx_s2_r)
            begin
              state_r <= ST_DATA;
              cnt_r <= `URB_BIT_CYCLES - 12'd1;
              bitn_r <= 4'h0;
              sh_data_r <= 9'h000;
              nbits_r <= size_bits(char_size_field);
              par_en_r <= parity_enable_bit;
              par_odd_r <= parity_odd_select;
            end
            else
              state_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 12'd1;
        end
        ST_DATA:
        begin
          if (cnt_r == 12'h000)
          begin
            sh_data_r[bitn_r] <= rx_s2_r;
            bitn_r <= bitn_r + 4'h1;
            cnt_r <= `URB_BIT_CYCLES - 12'd1;
            if (bitn_r == nbits_r - 4'h1)
              state_r <= par_en_r ? ST_PAR : ST_STOP;
          end
          else
            cnt_r <= cnt_r - 12'd1;
        end
        ST_PAR:
        begin
          if (cnt_r == 12'h000)
          begin
            par_bit_r <= rx_s2_r;
            cnt_r <= `URB_BIT_CYCLES - 12'd1;
            state_r <= ST_STOP;
          end
          else
            cnt_r <= cnt_r - 12'd1;
        end
        ST_STOP:
        begin
          // second stop bit is just idle line to the sequencer
          if (cnt_r == 12'h000)
          begin
            sh_fe_r <= ~rx_s2_r;
            sh_full_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 12'd1;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // even: data plus parity bit has even ones count
  wire par_mismatch = (^sh_data_r) ^ par_bit_r ^ par_odd_r;
  wire [11:0] entry = {dor_pend_r, par_en_r & par_mismatch, sh_fe_r, sh_data_r};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_entry
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mem_r[gi] <= 12'h000;
        else if (push && (wr_ptr_r == gi))
          mem_r[gi] <= entry;
      end
    end
  endgenerate

  // buffer pointers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end
    else if (!receiver_enable_bit)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push & ~pop)
        count_r <= count_r + 2'd1;
      else if (pop & ~push)
        count_r <= count_r - 2'd1;
    end
  end

  // stop count setting has no effect on reception
  wire unused_ok = stop_bit_count_select;

endmodule

`default_nettype wire

// ---- rtl/urb_pad.v ----
`default_nettype none
`default_nettype wire

// ---- tb/urb_rx_monitor.sv ----
`include "urb_map.vh"
`default_nettype none
module urb_rx_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pin and interrupt
  input wire logic rx_pin,
  input wire logic rx_pin_override,
  input wire logic global_irq_enable,
  input wire logic rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic stat_rd = acc && !pwrite && paddr == `URB_OFS_STATUS;
  logic ctlb_wr_r;
  logic ctlb_en_r;
  // holds a control b write for one cycle so an enable change can be traced to it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctlb_wr_r <= 1'b0;
      ctlb_en_r <= 1'b0;
    end
    else
    begin
      ctlb_wr_r <= acc && pwrite && paddr == `URB_OFS_CTRL_B;
      ctlb_en_r <= pwdata[`URB_CB_RECEIVER_ENABLE_BIT];
    end
  end
  a_ready_high: assert property (psel |-> pready) else $error("pready low during transfer");
  a_irq_gated: assert property (rx_irq |-> global_irq_enable) else $error("irq without global enable");
  a_irq_needs_enable: assert property (rx_irq |-> rx_pin_override) else $error("irq with receiver off");
  a_err_needs_frame: assert property (stat_rd && |prdata[4:2] |-> prdata[`URB_ST_RXC])
    else $error("error flag with empty buffer");
  a_empty_no_irq: assert property (stat_rd && !prdata[`URB_ST_RXC] |-> !rx_irq)
    else $error("irq while buffer empty");
  a_unmapped_err: assert property (acc && !pwrite && (paddr > `URB_OFS_DATA || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_enable_by_write: assert property ($changed(rx_pin_override) |-> ctlb_wr_r && rx_pin_override == ctlb_en_r)
    else $error("pin ownership changed without control write");
endmodule
bind urb_rx urb_rx_monitor urb_rx_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rx_pin(rx_pin), .rx_pin_override(rx_pin_override), .global_irq_enable(global_irq_enable), .rx_irq(rx_irq));
`default_nettype wire

// ---- tb/urb_tx_model.sv ----
`include "urb_map.vh"
`default_nettype none
module urb_tx_model (
  // clock
  input wire logic clk,
  // serial line, idles high
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic bit_out(input logic v);
    @(posedge clk);
    line <= v;
    repeat (`URB_BIT_CYCLES - 1) @(posedge clk);
  endtask
  // parity and stop values come from the caller so faults can be injected
  task automatic send(input logic [8:0] d, input int n, input logic par_on, input logic par, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < n; i++)
      bit_out(d[i]);
    if (par_on)
      bit_out(par);
    bit_out(stop);
    // a low stop needs a high gap, or the next start has no falling edge
    if (!stop)
      bit_out(1'b1);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`include "urb_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic gie = 0;
  logic rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  wire logic pready;
  wire logic pslverr;
  wire logic rx_irq;
  wire logic ovr;
  wire logic line;
  wire logic [31:0] prdata;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  urb_rx urb_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_pin(line),
    .rx_pin_override(ovr), .global_irq_enable(gie), .rx_irq(rx_irq));
  urb_tx_model urb_tx_model_inst (.clk(pclk), .line(line));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // hang guard, above the six frames of traffic
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`URB_OFS_CTRL_B, 32'h00);
    rchk(`URB_OFS_CTRL_C, 32'h06);
    rchk(`URB_OFS_STATUS, 32'h00);
    rchk(12'h010, 32'h00);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, `URB_OFS_CTRL_B, 32'h90);
    gie <= 1'b1;
    @(posedge pclk);
    chk({31'h0, ovr}, 32'h1);
    urb_tx_model_inst.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
    rchk(`URB_OFS_STATUS, 32'h80);
    chk({31'h0, rx_irq}, 32'h1);
    // even parity, two stop bits; wrong parity bit and a low first stop
    apb(1'b1, `URB_OFS_CTRL_C, 32'h2e);
    urb_tx_model_inst.send(9'h03c, 8, 1'b1, 1'b1, 1'b0);
    // odd parity frame with a correct bit waits in the shifter behind a full buffer
    apb(1'b1, `URB_OFS_CTRL_C, 32'h36);
    urb_tx_model_inst.send(9'h001, 8, 1'b1, 1'b0, 1'b1);
    // a further start now is lost to the overrun
    urb_tx_model_inst.send(9'h1ff, 1, 1'b0, 1'b0, 1'b1);
    rchk(`URB_OFS_STATUS, 32'h80);
    rchk(`URB_OFS_DATA, 32'ha5);
    rchk(`URB_OFS_STATUS, 32'h94);
    apb(1'b1, `URB_OFS_STATUS, 32'h00);
    rchk(`URB_OFS_STATUS, 32'h94);
    rchk(`URB_OFS_DATA, 32'h3c);
    rchk(`URB_OFS_STATUS, 32'h88);
    rchk(`URB_OFS_DATA, 32'h01);
    rchk(`URB_OFS_STATUS, 32'h00);
    chk({31'h0, rx_irq}, 32'h0);
    // nine data bits, parity off
    apb(1'b1, `URB_OFS_CTRL_C, 32'h06);
    apb(1'b1, `URB_OFS_CTRL_B, 32'h94);
    urb_tx_model_inst.send(9'h1a5, 9, 1'b0, 1'b0, 1'b1);
    rchk(`URB_OFS_CTRL_B, 32'h96);
    rchk(`URB_OFS_STATUS, 32'h80);
    gie <= 1'b0;
    @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h0);
    gie <= 1'b1;
    @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h1);
    // receiver off in mid-frame with the nine-bit frame still unread
    fork
      urb_tx_model_inst.send(9'h000, 1, 1'b0, 1'b0, 1'b1);
      begin
        repeat (2600) @(posedge pclk);
        apb(1'b1, `URB_OFS_CTRL_B, 32'h80);
      end
    join
    rchk(`URB_OFS_STATUS, 32'h00);
    chk({31'h0, ovr}, 32'h0);
    chk({31'h0, rx_irq}, 32'h0);
    apb(1'b1, `URB_OFS_CTRL_B, 32'h90);
    rchk(`URB_OFS_STATUS, 32'h00);
    summarize();
  end
endmodule
`default_nettype wire
